// *** src/pdu_pkg.sv ***
// constants for the pll and divider update control block
// Notes on behaviour
// - the memory divider field shapes the double-rate memory clock and is taken up only on a divider apply write.
// - the field is used only in synchronous memory mode, otherwise the memory pll output is divided by two.
// - the double-rate memory clock is halved again into a memory clock, and software keeps that equal to the system clock.
// - field values 0 and 7 divide by twelve, 6 by ten, 5 by eight, 4 by six, 3 by four, 2 by three and 1 by two.
// - the accelerator pll power-down bit powers that pll down and bypasses it when one, enables it when zero.
// - output divider sits in bits 15 to 13, input divider in 12 to 8, feedback divider in 7 to 0.
// - the input divider field loads its power-up value from strap levels on the external bus address lines.
// - a one written to the source-switch bit applies the pll selection and the bit then clears itself.
// - read-only lock bits show the accelerator and system pll lock state.
// - a one written to the divider apply bit applies the memory divider setting, then clears itself.
// - a one written to the accelerator reconfigure bit reloads that pll and the bit stays set until it locks.
// - a one written to the system reconfigure bit reloads the system pll and the bit clears once it locks.
package pdu_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ACCEL_CFG_OFFSET = 8'h04;
  localparam logic [7:0] CLK_UPDATE_OFFSET = 8'h08;
  localparam logic [31:0] ACCEL_CFG_RESET = 32'h2000_0000;
  localparam logic [31:0] CLK_UPDATE_RESET = 32'h0000_0030;
  // ----------------------------------------
  // accelerator pll configuration fields
  // ----------------------------------------
  localparam int MEM_DIV_LSB = 29;
  localparam int POWER_DOWN_BIT = 22;
  localparam int RANGE_LSB = 16;
  localparam int OUT_DIV_LSB = 13;
  localparam int IN_DIV_LSB = 8;
  localparam int FB_DIV_LSB = 0;
  // ----------------------------------------
  // clock update fields
  // ----------------------------------------
  localparam int SRC_SWITCH_BIT = 6;
  localparam int ACCEL_LOCK_BIT = 5;
  localparam int SYS_LOCK_BIT = 4;
  localparam int DIV_APPLY_BIT = 2;
  localparam int ACCEL_RECFG_BIT = 1;
  localparam int SYS_RECFG_BIT = 0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LOCK_SETTLE_NS = 40;
  localparam int LOCK_SETTLE_CYC = (LOCK_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] MEM_RATIO_ASYNC = 8'h02;
endpackage

// *** src/pdu_pll_seq.sv ***
// reconfiguration sequencer for one pll
`timescale 1ns/1ps
module pdu_pll_seq (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic pll_locked,
  output logic pll_load,
  output logic busy
);
  typedef enum logic [1:0] {PDU_IDLE, PDU_LOAD, PDU_SETTLE, PDU_WAIT_LOCK} pdu_seq_e;
  pdu_seq_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      PDU_IDLE: begin
        if (start) begin
          state_d = PDU_LOAD;
        end
      end
      PDU_LOAD: begin
        state_d = PDU_SETTLE;
        cnt_d = 8'(pdu_pkg::LOCK_SETTLE_CYC);
      end
      PDU_SETTLE: begin
        // lock from before the load is stale, so ignore it for a while
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          state_d = PDU_WAIT_LOCK;
        end
      end
      PDU_WAIT_LOCK: begin
        if (pll_locked) begin
          state_d = PDU_IDLE;
        end
      end
      default: state_d = PDU_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= PDU_IDLE;
      cnt_q <= 8'h00;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign pll_load = (state_q == PDU_LOAD);
  assign busy = (state_q != PDU_IDLE);

  property p_load_after_start;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_q == PDU_IDLE && start && ce) |=> pll_load;
  endproperty
  a_load_after_start: assert property (p_load_after_start) else $error("load missing");

  property p_busy_until_lock;
    @(posedge sys_clk) disable iff (!rst_n)
      (busy && !pll_locked) |=> busy;
  endproperty
  a_busy_until_lock: assert property (p_busy_until_lock) else $error("busy dropped early");
endmodule

// *** src/pdu_mem_div.sv ***
// memory clock enable divider
`timescale 1ns/1ps
module pdu_mem_div (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic mem_pll_tick,
  input wire logic [2:0] div_sel,
  input wire logic sync_mode,
  input wire logic apply,
  output logic mem_clk_2x_en,
  output logic mem_clk_en
);
  logic [2:0] active_q, active_d;
  logic [7:0] cnt_q, cnt_d;
  logic half_q, half_d;
  logic x2_q, x2_d;
  logic x1_q, x1_d;
  logic [7:0] ratio;

  function automatic logic [7:0] decode(input logic [2:0] sel);
    case (sel)
      3'h1: decode = 8'h02;
      3'h2: decode = 8'h03;
      3'h3: decode = 8'h04;
      3'h4: decode = 8'h06;
      3'h5: decode = 8'h08;
      3'h6: decode = 8'h0A;
      default: decode = 8'h0C;
    endcase
  endfunction

  assign ratio = sync_mode ? decode(active_q) : pdu_pkg::MEM_RATIO_ASYNC;

  always_comb begin
    active_d = apply ? div_sel : active_q;
    cnt_d = cnt_q;
    half_d = half_q;
    x2_d = 1'b0;
    x1_d = 1'b0;
    if (mem_pll_tick) begin
      if (cnt_q >= ratio - 8'h01) begin
        cnt_d = 8'h00;
        x2_d = 1'b1;
        half_d = ~half_q;
        x1_d = half_q;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      active_q <= pdu_pkg::ACCEL_CFG_RESET[pdu_pkg::MEM_DIV_LSB +: 3];
      cnt_q <= 8'h00;
      half_q <= 1'b0;
      x2_q <= 1'b0;
      x1_q <= 1'b0;
    end else if (ce) begin
      active_q <= active_d;
      cnt_q <= cnt_d;
      half_q <= half_d;
      x2_q <= x2_d;
      x1_q <= x1_d;
    end
  end

  assign mem_clk_2x_en = x2_q;
  assign mem_clk_en = x1_q;

  property p_hold_divider;
    @(posedge sys_clk) disable iff (!rst_n)
      (!apply) |=> $stable(active_q);
  endproperty
  a_hold_divider: assert property (p_hold_divider) else $error("divider moved without apply");

  property p_half_rate;
    @(posedge sys_clk) disable iff (!rst_n)
      mem_clk_en |-> mem_clk_2x_en;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("memory clock off its 2x edge");
endmodule

// *** src/pdu_top.sv ***
// pll and divider update control with apb register access
`timescale 1ns/1ps
module pdu_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] ext_bus_addr_strap,
  input wire logic mem_src_sync_strap,
  input wire logic accel_pll_locked,
  input wire logic sys_pll_locked,
  input wire logic mem_pll_tick,
  output logic accel_pll_power_down,
  output logic [2:0] accel_pll_range,
  output logic [2:0] pll_output_divider,
  output logic [4:0] pll_input_divider,
  output logic [7:0] pll_feedback_divider,
  output logic accel_pll_load,
  output logic sys_pll_load,
  output logic div_apply,
  output logic src_switch_apply,
  output logic mem_clk_2x_en,
  output logic mem_clk_en
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic setup, wr_access;
  logic hit_cfg, hit_upd;
  assign setup = psel && !penable && ce;
  assign wr_access = psel && penable && pwrite && ce;
  assign hit_cfg = (paddr == pdu_pkg::ACCEL_CFG_OFFSET);
  assign hit_upd = (paddr == pdu_pkg::CLK_UPDATE_OFFSET);
  // zero wait states, only a low ce stalls the bus
  assign pready = ce;
  assign pslverr = psel && penable && !(hit_cfg || hit_upd);

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  logic [2:0] mem_div_q, mem_div_d;
  logic pwr_dn_q, pwr_dn_d;
  logic [2:0] range_q, range_d;
  logic [2:0] out_div_q, out_div_d;
  logic [4:0] in_div_q, in_div_d;
  logic [7:0] fb_div_q, fb_div_d;
  logic strap_done_q, strap_done_d;
  logic mem_sync_q, mem_sync_d;

  always_comb begin
    mem_div_d = mem_div_q;
    pwr_dn_d = pwr_dn_q;
    range_d = range_q;
    out_div_d = out_div_q;
    in_div_d = in_div_q;
    fb_div_d = fb_div_q;
    strap_done_d = 1'b1;
    mem_sync_d = mem_sync_q;
    if (!strap_done_q) begin
      // straps caught on the first edge after release, never under reset
      in_div_d = ext_bus_addr_strap;
      mem_sync_d = mem_src_sync_strap;
    end else if (wr_access && hit_cfg) begin
      mem_div_d = pwdata[pdu_pkg::MEM_DIV_LSB +: 3];
      pwr_dn_d = pwdata[pdu_pkg::POWER_DOWN_BIT];
      range_d = pwdata[pdu_pkg::RANGE_LSB +: 3];
      out_div_d = pwdata[pdu_pkg::OUT_DIV_LSB +: 3];
      in_div_d = pwdata[pdu_pkg::IN_DIV_LSB +: 5];
      fb_div_d = pwdata[pdu_pkg::FB_DIV_LSB +: 8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_div_q <= pdu_pkg::ACCEL_CFG_RESET[pdu_pkg::MEM_DIV_LSB +: 3];
      pwr_dn_q <= pdu_pkg::ACCEL_CFG_RESET[pdu_pkg::POWER_DOWN_BIT];
      range_q <= pdu_pkg::ACCEL_CFG_RESET[pdu_pkg::RANGE_LSB +: 3];
      out_div_q <= pdu_pkg::ACCEL_CFG_RESET[pdu_pkg::OUT_DIV_LSB +: 3];
      in_div_q <= pdu_pkg::ACCEL_CFG_RESET[pdu_pkg::IN_DIV_LSB +: 5];
      fb_div_q <= pdu_pkg::ACCEL_CFG_RESET[pdu_pkg::FB_DIV_LSB +: 8];
      strap_done_q <= 1'b0;
      mem_sync_q <= 1'b0;
    end else if (ce) begin
      mem_div_q <= mem_div_d;
      pwr_dn_q <= pwr_dn_d;
      range_q <= range_d;
      out_div_q <= out_div_d;
      in_div_q <= in_div_d;
      fb_div_q <= fb_div_d;
      strap_done_q <= strap_done_d;
      mem_sync_q <= mem_sync_d;
    end
  end

  assign accel_pll_power_down = pwr_dn_q;
  assign accel_pll_range = range_q;
  assign pll_output_divider = out_div_q;
  assign pll_input_divider = in_div_q;
  assign pll_feedback_divider = fb_div_q;

  // ----------------------------------------
  // update requests
  // ----------------------------------------
  logic src_req_q, src_req_d;
  logic div_req_q, div_req_d;
  logic accel_busy, sys_busy;
  logic upd_wr;
  assign upd_wr = wr_access && hit_upd;

  always_comb begin
    // a one sets, a zero is ignored; set wins over the self clear
    src_req_d = (upd_wr && pwdata[pdu_pkg::SRC_SWITCH_BIT]) ||
                (src_req_q && !src_switch_apply);
    div_req_d = (upd_wr && pwdata[pdu_pkg::DIV_APPLY_BIT]) ||
                (div_req_q && !div_apply);
  end

  logic src_pulse_q, div_pulse_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      src_req_q <= 1'b0;
      div_req_q <= 1'b0;
      src_pulse_q <= 1'b0;
      div_pulse_q <= 1'b0;
    end else if (ce) begin
      src_req_q <= src_req_d;
      div_req_q <= div_req_d;
      src_pulse_q <= src_req_q && !src_pulse_q;
      div_pulse_q <= div_req_q && !div_pulse_q;
    end
  end

  assign src_switch_apply = src_pulse_q;
  assign div_apply = div_pulse_q;

  // the sequencer itself holds the busy state, so a zero write cannot cancel it
  pdu_pll_seq u_accel_seq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(upd_wr && pwdata[pdu_pkg::ACCEL_RECFG_BIT]),
    .pll_locked(accel_pll_locked),
    .pll_load(accel_pll_load),
    .busy(accel_busy)
  );

  pdu_pll_seq u_sys_seq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(upd_wr && pwdata[pdu_pkg::SYS_RECFG_BIT]),
    .pll_locked(sys_pll_locked),
    .pll_load(sys_pll_load),
    .busy(sys_busy)
  );

  pdu_mem_div u_mem_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .mem_pll_tick(mem_pll_tick),
    .div_sel(mem_div_q),
    .sync_mode(mem_sync_q),
    .apply(div_apply),
    .mem_clk_2x_en(mem_clk_2x_en),
    .mem_clk_en(mem_clk_en)
  );

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] rd_d, rd_q;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_cfg) begin
      rd_d[pdu_pkg::MEM_DIV_LSB +: 3] = mem_div_q;
      rd_d[pdu_pkg::POWER_DOWN_BIT] = pwr_dn_q;
      rd_d[pdu_pkg::RANGE_LSB +: 3] = range_q;
      rd_d[pdu_pkg::OUT_DIV_LSB +: 3] = out_div_q;
      rd_d[pdu_pkg::IN_DIV_LSB +: 5] = in_div_q;
      rd_d[pdu_pkg::FB_DIV_LSB +: 8] = fb_div_q;
    end else if (hit_upd) begin
      rd_d[pdu_pkg::SRC_SWITCH_BIT] = src_req_q;
      rd_d[pdu_pkg::ACCEL_LOCK_BIT] = accel_pll_locked;
      rd_d[pdu_pkg::SYS_LOCK_BIT] = sys_pll_locked;
      rd_d[pdu_pkg::DIV_APPLY_BIT] = div_req_q;
      rd_d[pdu_pkg::ACCEL_RECFG_BIT] = accel_busy;
      rd_d[pdu_pkg::SYS_RECFG_BIT] = sys_busy;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_q <= 32'h0000_0000;
    end else if (setup) begin
      rd_q <= rd_d;
    end
  end

  assign prdata = rd_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_div_self_clear;
    @(posedge sys_clk) disable iff (!rst_n || !ce)
      (div_req_q && !div_apply) |=> div_apply;
  endproperty
  a_div_self_clear: assert property (p_div_self_clear) else $error("apply pulse late");

  property p_src_self_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (src_switch_apply && ce && !(upd_wr && pwdata[pdu_pkg::SRC_SWITCH_BIT])) |=> !src_req_q;
  endproperty
  a_src_self_clear: assert property (p_src_self_clear) else $error("switch bit stuck");

  property p_zero_write_keeps;
    @(posedge sys_clk) disable iff (!rst_n)
      (div_req_q && !div_apply && ce) |=> div_req_q;
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("request lost");

  property p_power_down_follows;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_access && hit_cfg && strap_done_q) |=>
        accel_pll_power_down == $past(pwdata[pdu_pkg::POWER_DOWN_BIT]);
  endproperty
  a_power_down_follows: assert property (p_power_down_follows) else $error("power-down wrong");

  property p_strap_load;
    @(posedge sys_clk) disable iff (!rst_n)
      (!strap_done_q && ce) |=> pll_input_divider == $past(ext_bus_addr_strap);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not taken");

  property p_lock_readback;
    @(posedge sys_clk) disable iff (!rst_n)
      (setup && hit_upd) |=> prdata[pdu_pkg::SYS_LOCK_BIT] == $past(sys_pll_locked) &&
        prdata[pdu_pkg::ACCEL_LOCK_BIT] == $past(accel_pll_locked);
  endproperty
  a_lock_readback: assert property (p_lock_readback) else $error("lock bit wrong");
endmodule

// *** testbench/testbench.sv ***
// self-checking testbench for the pll and divider update control block
`timescale 1ns/1ps
module testbench;
  logic sys_clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] ext_bus_addr_strap, pll_input_divider;
  logic mem_src_sync_strap, accel_pll_locked, sys_pll_locked, mem_pll_tick;
  logic accel_pll_power_down, accel_pll_load, sys_pll_load, div_apply, src_switch_apply;
  logic [2:0] accel_pll_range, pll_output_divider, applied;
  logic [7:0] pll_feedback_divider;
  logic mem_clk_2x_en, mem_clk_en, e;
  logic [4:0] sig;
  logic [31:0] cfg, r, wd;
  int num_errors, n_tests, t, x, k;

  assign sig = {mem_clk_en, src_switch_apply, div_apply, accel_pll_load, sys_pll_load};

  pdu_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_bus_addr_strap(ext_bus_addr_strap),
    .mem_src_sync_strap(mem_src_sync_strap), .accel_pll_locked(accel_pll_locked),
    .sys_pll_locked(sys_pll_locked), .mem_pll_tick(mem_pll_tick),
    .accel_pll_power_down(accel_pll_power_down), .accel_pll_range(accel_pll_range),
    .pll_output_divider(pll_output_divider), .pll_input_divider(pll_input_divider),
    .pll_feedback_divider(pll_feedback_divider), .accel_pll_load(accel_pll_load),
    .sys_pll_load(sys_pll_load), .div_apply(div_apply), .src_switch_apply(src_switch_apply),
    .mem_clk_2x_en(mem_clk_2x_en), .mem_clk_en(mem_clk_en)
  );

  // ----------------------------------------
  // clock and memory pll ticks
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // tick every second cycle so tick counts differ from cycle counts
  always @(posedge sys_clk) begin
    mem_pll_tick <= ~mem_pll_tick;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // request held until the edge that sees pready high
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      num_errors++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  // bounded wait on one of the pulse outputs, n == lim means it never came
  task automatic wait_sig(input int s, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge sys_clk);
      if (sig[s] === 1'b1) break;
    end
  endtask

  // ticks and fast pulses over one full slow-clock period, phase independent
  task automatic measure(output int ticks, output int twox);
    int n;
    wait_sig(4, 200, n);
    chk(32'(n < 200), 32'h1);
    ticks = 0;
    twox = 0;
    for (n = 0; n < 200; n++) begin
      @(negedge sys_clk);
      ticks += (mem_pll_tick === 1'b1);
      twox += (mem_clk_2x_en === 1'b1);
      if (mem_clk_en === 1'b1) break;
    end
  endtask

  function automatic int nfor(input logic [2:0] c, input logic s);
    if (!s) return 2;
    case (c)
      3'h0, 3'h7: return 12;
      3'h6: return 10;
      3'h5: return 8;
      3'h4: return 6;
      3'h3: return 4;
      3'h2: return 3;
      default: return 2;
    endcase
  endfunction

  task automatic pchk();
    chk({12'h0, accel_pll_power_down, accel_pll_range, pll_output_divider, pll_input_divider,
      pll_feedback_divider}, {12'h0, cfg[22], cfg[18:0]});
  endtask

  task automatic do_reset(input logic sync);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    mem_src_sync_strap <= sync;
    ext_bus_addr_strap <= 5'($urandom());
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    cfg = 32'h2000_0000 | (32'(ext_bus_addr_strap) << 8);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, mem_pll_tick} = 5'h00;
    {paddr, pwdata, ext_bus_addr_strap} = 45'h0;
    {ce, accel_pll_locked, sys_pll_locked, mem_src_sync_strap} = 4'hF;
    void'($urandom(63));
    do_reset(1'b1);
    rd(pdu_pkg::ACCEL_CFG_OFFSET, cfg);
    rd(pdu_pkg::CLK_UPDATE_OFFSET, 32'h30);
    pchk();
    // clock enable low stalls the bus
    ce <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, pready}, 32'h0);
    ce <= 1'b1;
    for (k = 0; k < 8; k++) begin
      wd = (k == 0) ? 32'hFFFF_FFFF : $urandom();
      apb(1'b1, pdu_pkg::ACCEL_CFG_OFFSET, wd);
      cfg = wd & 32'hE047_FFFF;
      rd(pdu_pkg::ACCEL_CFG_OFFSET, cfg);
      pchk();
    end
    // divider codes: old ratio holds until apply, new one after
    applied = 3'h1;
    for (k = 0; k < 8; k++) begin
      cfg[31:29] = 3'(k);
      apb(1'b1, pdu_pkg::ACCEL_CFG_OFFSET, cfg);
      measure(t, x);
      chk(32'(t), 32'(2 * nfor(applied, 1'b1)));
      apb(1'b1, pdu_pkg::CLK_UPDATE_OFFSET, 32'h4);
      applied = 3'(k);
      // first period may straddle the apply, so let it pass
      measure(t, x);
      measure(t, x);
      chk(32'(t), 32'(2 * nfor(applied, 1'b1)));
      chk(32'(x), 32'h2);
    end
    // unmapped place: error response, nothing written
    apb(1'b0, 8'h0C, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd(pdu_pkg::ACCEL_CFG_OFFSET, cfg);
    // reconfigure: busy while unlocked, zero write cannot cancel
    for (k = 0; k < 2; k++) begin
      if (k == 0) sys_pll_locked <= 1'b0;
      else accel_pll_locked <= 1'b0;
      apb(1'b1, pdu_pkg::CLK_UPDATE_OFFSET, 32'h1 << k);
      wait_sig(k, 8, t);
      chk(32'(t < 8), 32'h1);
      wd = (32'h30 & ~(32'h10 << k)) | (32'h1 << k);
      rd(pdu_pkg::CLK_UPDATE_OFFSET, wd);
      apb(1'b1, pdu_pkg::CLK_UPDATE_OFFSET, 32'h0);
      rd(pdu_pkg::CLK_UPDATE_OFFSET, wd);
      {accel_pll_locked, sys_pll_locked} <= 2'h3;
      repeat (20) @(posedge sys_clk);
      rd(pdu_pkg::CLK_UPDATE_OFFSET, 32'h30);
    end
    // apply and source switch: single pulse, then bit clears
    for (k = 0; k < 2; k++) begin
      apb(1'b1, pdu_pkg::CLK_UPDATE_OFFSET, (k == 0) ? 32'h4 : 32'h40);
      wait_sig(2 + k, 8, t);
      chk(32'(t < 8), 32'h1);
      @(negedge sys_clk);
      chk({31'h0, sig[2 + k]}, 32'h0);
      rd(pdu_pkg::CLK_UPDATE_OFFSET, 32'h30);
    end
    // asynchronous memory source ignores the field
    do_reset(1'b0);
    rd(pdu_pkg::ACCEL_CFG_OFFSET, cfg);
    cfg[31:29] = 3'h5;
    apb(1'b1, pdu_pkg::ACCEL_CFG_OFFSET, cfg);
    apb(1'b1, pdu_pkg::CLK_UPDATE_OFFSET, 32'h4);
    measure(t, x);
    measure(t, x);
    chk(32'(t), 32'(2 * nfor(3'h5, 1'b0)));
    summarize();
  end
endmodule
